/* File: hw/branch_unit.sv */
// branch unit: folding, fall-through removal, target fetch, prediction
// assumes fetcher, dispatch and completion logic on the same clock
`timescale 1ns/100ps

module branch_unit
   import bu_pkg::*;
#(
   parameter int HIST_N = HIST_ENTRIES,
   parameter int IDX_W  = $clog2(HIST_N)
)
(
   // clock and reset
   input  wire logic             clock_i,
   input  wire logic             rst_n_i,
   // configuration
   input  wire logic             hist_enable_i,
   // branch seen by the fetcher
   input  wire logic             br_valid_i,
   input  wire logic             br_uncond_i,
   input  wire logic             br_cond_cr_i,
   input  wire logic             br_cond_taken_i,
   input  wire logic             br_hint_taken_i,
   input  wire logic             br_ctr_decides_i,
   input  wire logic             br_ctr_taken_i,
   input  wire logic             br_count_dec_i,
   input  wire logic             br_link_target_i,
   input  wire logic             br_count_target_i,
   input  wire logic             br_writes_link_i,
   input  wire logic             br_writes_count_i,
   input  wire logic [IDX_W-1:0] br_index_i,
   // dependencies
   input  wire logic             cr_pend_i,
   input  wire logic             mtspr_link_pend_i,
   input  wire logic             mtspr_count_pend_i,
   // condition resolution of oldest open branch
   input  wire logic             resolve_valid_i,
   input  wire logic             resolve_taken_i,
   // caches
   input  wire logic             target_instruction_cache_hit_i,
   input  wire logic             target_instruction_cache_last_i,
   input  wire logic             icache_hit_i,
   input  wire logic             refill_done_i,
   // dispatch and completion
   input  wire logic [1:0]       dispatch_req_i,
   input  wire logic [1:0]       finished_i,
   // branch decisions
   output logic                  fold_o,
   output logic                  drop_o,
   output logic                  cq_slot_o,
   output logic                  predict_taken_o,
   // fetch control
   output logic [1:0]            target_instruction_cache_count_o,
   output logic                  icache_fetch_o,
   output logic                  iq_fill_block_o,
   output logic                  fetch_halt_o,
   output logic                  flush_o,
   output logic                  exec_block_o,
   // completion control
   output logic                  dispatch_stall_o,
   output logic [1:0]            retire_count_o,
   output logic                  count_commit_o,
   output logic                  link_commit_o,
   output logic [1:0]            unresolved_o
);

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      fetch_state_e              fs;
      logic                      last;
      logic [1:0]                unres;
      logic [1:0]                pred;
      logic [1:0][IDX_W-1:0]     idx;
      logic                      cnt_commit;
      logic                      lnk_commit;
   } bu_s;

   bu_s  s_reg;
   bu_s  s_next;

   logic hist_pred;
   logic cq_full;
   logic hold_dep;
   logic hold_slot;
   logic cr_blocked;
   logic third;
   logic fetch_ok;
   logic mispredict;
   logic correct;
   logic accept;
   logic pred_dir;
   logic taken;
   logic writes;
   logic fold;
   logic drop;
   logic slot;

   // ****************************************
   // branch decision
   // ****************************************
   always_comb
   begin
      s_next            = s_reg;
      s_next.cnt_commit = 1'b0;
      s_next.lnk_commit = 1'b0;

      // register moves are not forwarded before execute
      hold_dep   = br_valid_i
                   & ((br_link_target_i & mtspr_link_pend_i)
                   | ((br_count_target_i | br_count_dec_i)
                   & mtspr_count_pend_i));
      cr_blocked = br_cond_cr_i & cr_pend_i & ~br_ctr_decides_i;
      third      = br_valid_i & cr_blocked
                   & (s_reg.unres == 2'(PRED_LEVELS));
      writes     = br_writes_link_i | br_writes_count_i;
      hold_slot  = br_valid_i & writes & cq_full;
      fetch_ok   = (s_reg.fs == FS_SEQ) || (s_reg.fs == FS_TARGET_INSTRUCTION_CACHE)
                   || (s_reg.fs == FS_GROUP);
      mispredict = resolve_valid_i & (s_reg.unres != 2'h0)
                   & (resolve_taken_i != s_reg.pred[0]);
      correct    = resolve_valid_i & (s_reg.unres != 2'h0) & ~mispredict;
      accept     = br_valid_i & fetch_ok & ~hold_dep & ~third
                   & ~hold_slot & ~mispredict;

      // static guess whenever the table is switched off
      pred_dir   = hist_enable_i ? hist_pred : br_hint_taken_i;

      if (br_uncond_i)
         taken = 1'b1;
      else if (br_ctr_decides_i)
         taken = br_ctr_taken_i;
      else if (cr_blocked)
         taken = pred_dir;
      else
         taken = br_cond_taken_i;

      // target stream overwrites the branch, no dispatch cycle spent
      fold = accept & taken;
      drop = accept & ~taken & ~writes;
      slot = accept & writes;

      // ****************************************
      // two-level open branch stack
      // ****************************************
      if (correct)
      begin
         s_next.pred[0] = s_reg.pred[1];
         s_next.idx[0]  = s_reg.idx[1];
         s_next.unres   = s_reg.unres - 2'h1;
      end
      if (accept && cr_blocked)
      begin
         // second level is fetched only, see exec_block_o
         s_next.pred[s_next.unres[0]] = pred_dir;
         s_next.idx[s_next.unres[0]]  = br_index_i;
         s_next.unres                 = s_next.unres + 2'h1;
      end

      // ****************************************
      // target fetch sequence
      // ****************************************
      case (s_reg.fs)
         FS_TARGET_INSTRUCTION_CACHE:   s_next.fs = FS_GROUP;
         FS_IDLE:   s_next.fs = FS_GROUP;
         FS_REFILL:
         begin
            if (refill_done_i)
               s_next.fs = FS_SEQ;
         end
         FS_GROUP:  s_next.fs = FS_SEQ;
         FS_SEQ:    s_next.fs = FS_SEQ;
         default:   s_next.fs = FS_SEQ;
      endcase

      if (fold)
      begin
         if (target_instruction_cache_hit_i)
         begin
            s_next.fs   = FS_TARGET_INSTRUCTION_CACHE;
            s_next.last = target_instruction_cache_last_i;
         end
         else if (icache_hit_i)
            s_next.fs = FS_IDLE;
         else
            s_next.fs = FS_REFILL;
      end

      // slot sits at the head, so it retires next cycle
      s_next.cnt_commit = slot & br_writes_count_i;
      s_next.lnk_commit = slot & br_writes_link_i;

      // wrong path: drop all open levels, one refetch cycle
      if (mispredict)
      begin
         s_next.unres = 2'h0;
         s_next.fs    = FS_IDLE;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         s_reg    <= '0;
         s_reg.fs <= FS_SEQ;
      end
      else
         s_reg <= s_next;
   end

   // ****************************************
   // submodules
   // ****************************************
   branch_history #(
      .ENTRIES     (HIST_N),
      .IDX_W       (IDX_W)
   ) u_hist (
      .clock_i     (clock_i),
      .rst_n_i     (rst_n_i),
      .rd_idx_i    (br_index_i),
      .pred_o      (hist_pred),
      .upd_i       (resolve_valid_i && (s_reg.unres != 2'h0)),
      .upd_idx_i   (s_reg.idx[0]),
      .upd_taken_i (resolve_taken_i)
   );

   completion_queue #(
      .DEPTH        (CQ_DEPTH),
      .RETIRE       (CQ_RETIRE_MAX)
   ) u_cq (
      .clock_i      (clock_i),
      .rst_n_i      (rst_n_i),
      .alloc_i      (dispatch_req_i),
      .stall_o      (dispatch_stall_o),
      .full_o       (cq_full),
      .finished_i   (finished_i),
      .retire_o     (retire_count_o),
      .level_i      (s_reg.unres),
      .resolve_ok_i (correct),
      .flush_i      (mispredict)
   );

   // ****************************************
   // outputs
   // ****************************************
   assign fold_o          = fold;
   assign drop_o          = drop;
   assign cq_slot_o       = slot;
   assign predict_taken_o = pred_dir;
   assign target_instruction_cache_count_o    = (s_reg.fs != FS_TARGET_INSTRUCTION_CACHE) ? TARGET_INSTRUCTION_CACHE_NONE
                            : (s_reg.last ? TARGET_INSTRUCTION_CACHE_SINGLE : TARGET_INSTRUCTION_CACHE_PAIR);
   assign icache_fetch_o  = s_reg.fs == FS_GROUP;
   assign iq_fill_block_o = (s_reg.fs == FS_IDLE) || (s_reg.fs == FS_REFILL);
   assign fetch_halt_o    = hold_dep | third | hold_slot;
   assign flush_o         = mispredict;
   assign exec_block_o    = s_reg.unres == 2'(PRED_LEVELS);
   assign count_commit_o  = s_reg.cnt_commit;
   assign link_commit_o   = s_reg.lnk_commit;
   assign unresolved_o    = s_reg.unres;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   sequence seq_target_instruction_cache_then_group;
      (target_instruction_cache_count_o != TARGET_INSTRUCTION_CACHE_NONE) ##1 icache_fetch_o;
   endsequence

   sequence seq_idle_then_group;
      (iq_fill_block_o && !icache_fetch_o) ##1 icache_fetch_o;
   endsequence

   chk_drop_no_slot: assert property (
      drop_o |-> !cq_slot_o && !fold_o && !br_writes_link_i && !br_writes_count_i)
      else $error("dropped branch took a slot");
   chk_fold_taken: assert property (
      br_valid_i && br_uncond_i && fetch_ok && !fetch_halt_o && !flush_o |-> fold_o)
      else $error("unconditional branch not folded");
   chk_target_instruction_cache_seq: assert property (
      fold_o && target_instruction_cache_hit_i |=> seq_target_instruction_cache_then_group)
      else $error("target hit sequence wrong");
   chk_miss_idle: assert property (
      fold_o && !target_instruction_cache_hit_i && icache_hit_i |=> seq_idle_then_group)
      else $error("target miss idle cycle missing");
   chk_fall_drop: assert property (
      br_valid_i && fetch_ok && !fetch_halt_o && !flush_o && !br_uncond_i
      && !br_cond_cr_i && !br_ctr_decides_i && !br_cond_taken_i
      && !br_writes_link_i && !br_writes_count_i |-> drop_o)
      else $error("fall-through branch kept");
   chk_slot_writer: assert property (
      cq_slot_o |=> (link_commit_o == $past(br_writes_link_i)))
      else $error("link commit mismatch");
   chk_count_commit: assert property (
      cq_slot_o && br_writes_count_i |=> count_commit_o ##1 !count_commit_o[*1])
      else $error("count commit not one cycle after slot");
   chk_static_pred: assert property (
      !hist_enable_i |-> predict_taken_o == br_hint_taken_i)
      else $error("static prediction not used");
   chk_blocked_push: assert property (
      br_valid_i && cr_blocked && !fetch_halt_o && fetch_ok && !flush_o
      && !resolve_valid_i |=> unresolved_o == $past(unresolved_o) + 2'h1)
      else $error("blocked branch not predicted");
   chk_flush_refetch: assert property (
      flush_o |=> (unresolved_o == 2'h0) and seq_idle_then_group)
      else $error("misprediction recovery wrong");
   chk_third_halt: assert property (
      br_valid_i && cr_blocked && (unresolved_o == 2'h2)
      |-> fetch_halt_o && !fold_o && !drop_o && !cq_slot_o)
      else $error("third open branch not halted");
   chk_target_instruction_cache_single: assert property (
      fold_o && target_instruction_cache_hit_i && target_instruction_cache_last_i |=> target_instruction_cache_count_o == TARGET_INSTRUCTION_CACHE_SINGLE)
      else $error("block-end target gave two");
   chk_move_halt: assert property (
      br_valid_i && br_link_target_i && mtspr_link_pend_i
      |-> fetch_halt_o && !fold_o && !drop_o)
      else $error("fetch ran past pending move");
   chk_ctr_ignores_cr: assert property (
      br_valid_i && br_ctr_decides_i && !br_uncond_i && !fetch_halt_o && fetch_ok && !flush_o
      |-> (fold_o == br_ctr_taken_i) ##1 (unresolved_o <= $past(unresolved_o)))
      else $error("count-decided branch waited");
   chk_refill_block: assert property (
      fold_o && !target_instruction_cache_hit_i && !icache_hit_i |=> iq_fill_block_o && !icache_fetch_o)
      else $error("queue filled before refill");
   chk_refill_hold: assert property (
      (s_reg.fs == FS_REFILL) && !refill_done_i |=> iq_fill_block_o)
      else $error("queue filled during refill");

endmodule

/* File: hw/bu_pkg.sv */
// branch unit shared constants, fetch states
// assumes one processor clock domain
package bu_pkg;

   // ****************************************
   // completion queue
   // ****************************************
   localparam int CQ_DEPTH      = 8;
   localparam int CQ_RETIRE_MAX = 2;

   // ****************************************
   // prediction
   // ****************************************
   localparam int         PRED_LEVELS  = 2;
   localparam int         HIST_ENTRIES = 64;
   localparam logic [1:0] HIST_RESET   = 2'h1;
   localparam logic [1:0] HIST_MAX     = 2'h3;
   localparam logic [1:0] HIST_MIN     = 2'h0;

   // ****************************************
   // target fetch
   // ****************************************
   localparam logic [1:0] TARGET_INSTRUCTION_CACHE_PAIR    = 2'h2;
   localparam logic [1:0] TARGET_INSTRUCTION_CACHE_SINGLE  = 2'h1;
   localparam logic [1:0] TARGET_INSTRUCTION_CACHE_NONE    = 2'h0;

   typedef enum logic [2:0] {
      FS_SEQ,
      FS_TARGET_INSTRUCTION_CACHE,
      FS_GROUP,
      FS_IDLE,
      FS_REFILL
   } fetch_state_e;

endpackage

/* File: hw/branch_history.sv */
// two-bit saturating direction counters, one per entry
// assumes updates come only from resolved branches
`timescale 1ns/100ps
module branch_history
   import bu_pkg::*;
#(
   parameter int ENTRIES = HIST_ENTRIES,
   parameter int IDX_W   = $clog2(ENTRIES)
)
(
   // clock and reset
   input  wire logic             clock_i,
   input  wire logic             rst_n_i,
   // lookup
   input  wire logic [IDX_W-1:0] rd_idx_i,
   output logic                  pred_o,
   // training
   input  wire logic             upd_i,
   input  wire logic [IDX_W-1:0] upd_idx_i,
   input  wire logic             upd_taken_i
);

   typedef struct packed {
      logic [ENTRIES-1:0][1:0] ctr;
   } hist_s;

   hist_s                   s_reg;
   hist_s                   s_next;
   logic [ENTRIES-1:0][1:0] nxt;

   // ****************************************
   // per-entry counter update
   // ****************************************
   for (genvar g = 0; g < ENTRIES; g++)
   begin : g_ent
      logic [1:0] c;
      assign c = s_reg.ctr[g];
      always_comb
      begin
         nxt[g] = c;
         if (upd_i && (upd_idx_i == IDX_W'(g)))
         begin
            if (upd_taken_i && (c != HIST_MAX))
               nxt[g] = c + 2'h1;
            else if (!upd_taken_i && (c != HIST_MIN))
               nxt[g] = c - 2'h1;
         end
      end
   end

   always_comb
   begin
      s_next     = s_reg;
      s_next.ctr = nxt;
   end

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         s_reg <= {ENTRIES{HIST_RESET}};
      else
         s_reg <= s_next;
   end

   // upper bit of counter is the guess
   assign pred_o = s_reg.ctr[rd_idx_i][1];

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   chk_hist_train: assert property (
      upd_i && upd_taken_i && (upd_idx_i == rd_idx_i) && (s_reg.ctr[rd_idx_i] == 2'h1)
      && $stable(rd_idx_i) |=> s_reg.ctr[$past(upd_idx_i)] == 2'h2)
      else $error("history counter did not move toward taken");

endmodule

/* File: hw/completion_queue.sv */
// completion queue occupancy with speculative fences
// assumes finished_i counts finished entries at the head, in order
`timescale 1ns/100ps
module completion_queue
   import bu_pkg::*;
#(
   parameter int DEPTH  = CQ_DEPTH,
   parameter int RETIRE = CQ_RETIRE_MAX,
   parameter int CW     = $clog2(DEPTH + 1)
)
(
   // clock and reset
   input  wire logic       clock_i,
   input  wire logic       rst_n_i,
   // dispatch side
   input  wire logic [1:0] alloc_i,
   output logic            stall_o,
   output logic            full_o,
   // completion side
   input  wire logic [1:0] finished_i,
   output logic [1:0]      retire_o,
   // branch resolution
   input  wire logic [1:0] level_i,
   input  wire logic       resolve_ok_i,
   input  wire logic       flush_i
);

   typedef struct packed {
      logic [CW-1:0] total;
      logic [CW-1:0] spec0;
      logic [CW-1:0] spec1;
   } cq_s;

   cq_s           s_reg;
   cq_s           s_next;
   logic [CW-1:0] free;
   logic [CW-1:0] avail;
   logic [CW-1:0] ret;
   logic [CW-1:0] add;
   logic [1:0]    lvl;

   always_comb
   begin
      s_next  = s_reg;
      free    = CW'(DEPTH) - s_reg.total;
      // entries behind an open branch wait here, not written back
      avail   = s_reg.total - s_reg.spec0;
      ret     = CW'(finished_i);
      if (ret > avail)
         ret = avail;
      if (ret > CW'(RETIRE))
         ret = CW'(RETIRE);
      stall_o = CW'(alloc_i) > free;
      add     = (stall_o || flush_i) ? '0 : CW'(alloc_i);
      lvl     = level_i - {1'b0, resolve_ok_i};
      if (flush_i)
      begin
         s_next.total = s_reg.total - s_reg.spec0 - ret;
         s_next.spec0 = '0;
         s_next.spec1 = '0;
      end
      else
      begin
         if (resolve_ok_i)
         begin
            s_next.spec0 = s_reg.spec1;
            s_next.spec1 = '0;
         end
         s_next.total = s_reg.total - ret + add;
         if (lvl != 2'h0)
            s_next.spec0 = s_next.spec0 + add;
         if (lvl == 2'h2)
            s_next.spec1 = s_next.spec1 + add;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign full_o   = s_reg.total == CW'(DEPTH);
   assign retire_o = ret[1:0];

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   chk_cq_bound: assert property (s_reg.total <= CW'(DEPTH))
      else $error("completion queue over eight entries");
   chk_spec_wait: assert property (
      (s_reg.spec0 == s_reg.total) |-> (retire_o == 2'h0))
      else $error("speculative entry retired");
   chk_flush_empty: assert property (
      flush_i && (s_reg.spec0 == s_reg.total) |=> s_reg.total == '0)
      else $error("flush left younger entries");

endmodule

/* File: bench/cq_partner.sv */
// completion unit model: reports finished entries at the queue head
// assumes it sees the branch unit's dispatch, stall, retire and flush
`timescale 1ns/100ps
module cq_partner
(
   // clock and reset
   input  wire logic       clock_i,
   input  wire logic       rst_n_i,
   // queue traffic
   input  wire logic       slow_i,
   input  wire logic [1:0] dispatch_req_i,
   input  wire logic       stall_i,
   input  wire logic [1:0] retire_i,
   input  wire logic       flush_i,
   output logic [1:0]      finished_o
);
   // ****************************************
   // occupancy
   // ****************************************
   logic [3:0] occ_reg;

   // slow mode finishes nothing, so the queue can be filled
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         occ_reg <= 4'h0;
      else if (flush_i)
         occ_reg <= 4'h0;
      else
         occ_reg <= occ_reg + (stall_i ? 4'h0 : {2'h0, dispatch_req_i}) - {2'h0, retire_i};
   end

   // never claims more than the queue holds
   assign finished_o = slow_i ? 2'h0 : ((occ_reg > 4'h1) ? 2'h2 : occ_reg[1:0]);
endmodule

/* File: bench/tb_top.sv */
// testbench: branch unit against a completion model and queued expectations
// assumes the design package and the completion model are compiled first
`timescale 1ns/100ps
module tb_top;
   // ****************************************
   // signals and instances
   // ****************************************
   logic        clock_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        hist_en, br_valid, cr_pend, mt_link, mt_count, res_v, res_t;
   logic        b_hit, b_last, i_hit, refill, slow;
   logic [10:0] ba;
   logic [5:0]  idx;
   logic [1:0]  dreq, fin, bcount, retire, unres;
   logic        fold, drop, slot, pred, ifetch, fblock, halt, flush, xblock, stall, ccommit, lcommit;
   logic [2:0]  exp_q[$];
   logic [31:0] seed;
   int          n_errors = 0;
   int          tests_run = 0;
   int          i;

   always #5 clock_i = ~clock_i;

   branch_unit DUT
   (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .hist_enable_i(hist_en), .br_valid_i(br_valid),
      .br_uncond_i(ba[10]), .br_cond_cr_i(ba[9]), .br_cond_taken_i(ba[8]), .br_hint_taken_i(ba[7]),
      .br_ctr_decides_i(ba[6]), .br_ctr_taken_i(ba[5]), .br_count_dec_i(ba[4]), .br_link_target_i(ba[3]),
      .br_count_target_i(ba[2]), .br_writes_link_i(ba[1]), .br_writes_count_i(ba[0]), .br_index_i(idx),
      .cr_pend_i(cr_pend), .mtspr_link_pend_i(mt_link), .mtspr_count_pend_i(mt_count),
      .resolve_valid_i(res_v), .resolve_taken_i(res_t), .target_instruction_cache_hit_i(b_hit), .target_instruction_cache_last_i(b_last),
      .icache_hit_i(i_hit), .refill_done_i(refill), .dispatch_req_i(dreq), .finished_i(fin),
      .fold_o(fold), .drop_o(drop), .cq_slot_o(slot), .predict_taken_o(pred), .target_instruction_cache_count_o(bcount),
      .icache_fetch_o(ifetch), .iq_fill_block_o(fblock), .fetch_halt_o(halt), .flush_o(flush),
      .exec_block_o(xblock), .dispatch_stall_o(stall), .retire_count_o(retire),
      .count_commit_o(ccommit), .link_commit_o(lcommit), .unresolved_o(unres)
   );

   cq_partner MODEL
   (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .slow_i(slow), .dispatch_req_i(dreq), .stall_i(stall),
      .retire_i(retire), .flush_i(flush), .finished_o(fin)
   );

   // ****************************************
   // tasks and monitor
   // ****************************************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // empty queue yields zero, so an unexpected pulse still mismatches
   function automatic logic [3:0] pop_exp;
      return exp_q.size() ? {1'b0, exp_q.pop_front()} : 4'h0;
   endfunction

   task automatic chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic cyc;
      @(negedge clock_i);
   endtask

   // branch held until the unit accepts it
   task automatic present(input logic [10:0] a, input logic [2:0] e, input logic [2:0] c);
      @(posedge clock_i);
      seed = lfsr(seed);
      ba <= a;
      idx <= seed[5:0];
      {b_hit, b_last, i_hit} <= c;
      br_valid <= 1'b1;
      exp_q.push_back(e);
   endtask

   task automatic wait_accept;
      int k;
      for (k = 0; k < 20; k++)
      begin
         cyc();
         if (fold || drop || slot)
            break;
      end
      if (k == 20)
      begin
         n_errors++;
         give_verdict();
      end
      @(posedge clock_i);
      br_valid <= 1'b0;
   endtask

   task automatic send(input logic [10:0] a, input logic [2:0] e, input logic [2:0] c);
      present(a, e, c);
      wait_accept();
   endtask

   // decision pulses: fold, drop, slot
   always @(negedge clock_i)
   begin
      if (rst_n_i && (fold || drop || slot))
         chk("decision", {1'b0, fold, drop, slot}, pop_exp());
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      {hist_en, br_valid, ba, idx, cr_pend, mt_link, mt_count, res_v, res_t} = '0;
      {b_hit, b_last, i_hit, refill, slow, dreq} = '0;
      seed = 32'hA82F1C58;
      repeat (4) @(posedge clock_i);
      rst_n_i <= 1'b1;
      slow <= 1'b1;
      for (i = 0; i < 5; i++)
      begin
         @(posedge clock_i);
         dreq <= (i < 4) ? 2'h2 : 2'h1;
         cyc();
         chk("stall", 4'(stall), (i < 4) ? 4'h0 : 4'h1);
      end
      @(posedge clock_i);
      dreq <= 2'h0;
      slow <= 1'b0;
      for (i = 0; i < 5; i++)
      begin
         cyc();
         chk("retire", 4'(retire), (i < 4) ? 4'h2 : 4'h0);
      end
      $display("test completion finished");
      for (i = 0; i < 2; i++)
      begin
         send(11'h400, 3'h4, {1'b1, i[0], 1'b1});
         cyc();
         chk("target pair", 4'(bcount), i ? 4'h1 : 4'h2);
         cyc();
         chk("group fetch", 4'(ifetch), 4'h1);
      end
      send(11'h100, 3'h4, 3'h1);
      cyc();
      chk("idle cycle", 4'(fblock), 4'h1);
      cyc();
      chk("group fetch", 4'(ifetch), 4'h1);
      send(11'h400, 3'h4, 3'h0);
      repeat (3)
      begin
         cyc();
         chk("refill wait", 4'(fblock), 4'h1);
      end
      @(posedge clock_i);
      refill <= 1'b1;
      @(posedge clock_i);
      refill <= 1'b0;
      cyc();
      chk("refill end", 4'(fblock), 4'h0);
      send(11'h000, 3'h2, 3'h7);
      send(11'h011, 3'h1, 3'h7);
      cyc();
      chk("count commit", 4'(ccommit), 4'h1);
      send(11'h002, 3'h1, 3'h7);
      cyc();
      chk("link commit", 4'(lcommit), 4'h1);
      $display("test fetch finished");
      @(posedge clock_i);
      hist_en <= 1'b1;
      cr_pend <= 1'b1;
      send(11'h280, 3'h2, 3'h7);
      cyc();
      chk("open one", 4'(unres), 4'h1);
      @(posedge clock_i);
      hist_en <= 1'b0;
      send(11'h280, 3'h4, 3'h7);
      cyc();
      chk("exec block", {1'b0, xblock, unres}, 4'h6);
      present(11'h280, 3'h4, 3'h7);
      cyc();
      chk("third halt", {2'h0, halt, pred}, 4'h3);
      @(posedge clock_i);
      res_v <= 1'b1;
      cyc();
      chk("right guess", 4'(flush), 4'h0);
      @(posedge clock_i);
      res_v <= 1'b0;
      wait_accept();
      @(posedge clock_i);
      res_v <= 1'b1;
      cyc();
      chk("mispredict", 4'(flush), 4'h1);
      @(posedge clock_i);
      res_v <= 1'b0;
      cyc();
      chk("purge", {1'b0, fblock, unres}, 4'h4);
      cyc();
      chk("refetch", 4'(ifetch), 4'h1);
      send(11'h240, 3'h2, 3'h7);
      cyc();
      chk("count decides", 4'(unres), 4'h0);
      // fresh history entry guesses not taken, entries dispatched behind it wait
      @(posedge clock_i);
      hist_en <= 1'b1;
      send(11'h200, 3'h2, 3'h7);
      dreq <= 2'h2;
      @(posedge clock_i);
      {res_v, res_t, dreq} <= 4'hC;
      cyc();
      chk("fenced retire", 4'(retire), 4'h0);
      chk("taken resolve", 4'(flush), 4'h1);
      @(posedge clock_i);
      {res_v, res_t, dreq} <= 4'h0;
      cyc();
      chk("trained guess", 4'(pred), 4'h1);
      for (i = 0; i < 2; i++)
      begin
         @(posedge clock_i);
         {mt_link, mt_count} <= i ? 2'h1 : 2'h2;
         present(i ? 11'h404 : 11'h408, 3'h4, 3'h7);
         cyc();
         chk("move wait", 4'(halt), 4'h1);
         @(posedge clock_i);
         {mt_link, mt_count} <= 2'h0;
         wait_accept();
      end
      $display("test prediction finished");
      give_verdict();
   end
endmodule
